// file: design/lpts_map.svh
`ifndef LPTS_MAP_SVH
`define LPTS_MAP_SVH

// Register byte offsets
`define LPTS_GEOM_OFFSET     12'h000
`define LPTS_FORMAT_OFFSET   12'h004
`define LPTS_SELECT_OFFSET   12'h008
`define LPTS_TIMING_OFFSET   12'h00C
`define LPTS_PIXEL_OFFSET    12'h010

// Geometry register fields
`define LPTS_WIDTH_MSB       18
`define LPTS_WIDTH_LSB       8
`define LPTS_WIDTH_RESET     11'h000

// Format/status register fields
`define LPTS_FRAME_MSB       16
`define LPTS_FRAME_LSB       15
`define LPTS_LINE_MSB        14
`define LPTS_LINE_LSB        13
`define LPTS_LAYOUT_BIT      11
`define LPTS_TFT_BIT         0

// Select register fields
`define LPTS_ENABLE_BIT      0
`define LPTS_RES_BIT         1

// Timing register fields: hsync, hback, hfront, vsync, vback, vfront, lines
`define LPTS_TIMING_RESET    32'h0000_0000

`endif

// file: design/lpts_pkg.sv
package lpts_pkg;

    typedef enum logic [1:0] {
        LPTS_PH_SYNC  = 2'b00,
        LPTS_PH_BACK  = 2'b01,
        LPTS_PH_ACTV  = 2'b10,
        LPTS_PH_FRONT = 2'b11
    } lpts_phase_e;

    typedef struct packed {
        logic [4:0] red;
        logic [5:0] green;
        logic [4:0] blue;
    } lpts_pix565_s;

    typedef struct packed {
        logic [10:0] width;
        logic [3:0]  hsync;
        logic [3:0]  hback;
        logic [3:0]  hfront;
        logic [3:0]  vsync;
        logic [3:0]  vback;
        logic [3:0]  vfront;
        logic [9:0]  lines;
    } lpts_timing_s;

    typedef logic [23:0] lpts_vd_t;

endpackage

// file: design/lpts_phase_cnt.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Phase sequencer: sync, back porch, active, front porch
// ------------------------------------------------------------
module lpts_phase_cnt
    import lpts_pkg::*;
#(
    parameter int W = 11
) (
    input  wire logic         ref_clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         run_in,
    input  wire logic         step_in,
    input  wire logic [W-1:0] sync_len_in,
    input  wire logic [W-1:0] back_len_in,
    input  wire logic [W-1:0] actv_len_in,
    input  wire logic [W-1:0] front_len_in,
    output lpts_phase_e       phase_out,
    output logic              wrap_out
);

    lpts_phase_e  next_phase;
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic [W-1:0] len;

    always_comb begin
        case (phase_out)
            LPTS_PH_SYNC:  len = sync_len_in;
            LPTS_PH_BACK:  len = back_len_in;
            LPTS_PH_ACTV:  len = actv_len_in;
            LPTS_PH_FRONT: len = front_len_in;
            default:       len = sync_len_in;
        endcase
        next_phase = phase_out;
        next_count = count;
        wrap_out   = 1'b0;
        if (!run_in) begin
            next_phase = LPTS_PH_SYNC;
            next_count = '0;
        end else if (step_in) begin
            if (count >= len) begin
                next_count = '0;
                case (phase_out)
                    LPTS_PH_SYNC:  next_phase = LPTS_PH_BACK;
                    LPTS_PH_BACK:  next_phase = LPTS_PH_ACTV;
                    LPTS_PH_ACTV:  next_phase = LPTS_PH_FRONT;
                    LPTS_PH_FRONT: begin
                        next_phase = LPTS_PH_SYNC;
                        wrap_out   = 1'b1;
                    end
                    default:       next_phase = LPTS_PH_SYNC;
                endcase
            end else begin
                next_count = count + W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_out <= LPTS_PH_SYNC;
            count     <= '0;
        end else begin
            phase_out <= next_phase;
            count     <= next_count;
        end
    end

endmodule // lpts_phase_cnt

// file: design/lcd_panel_timing_status.sv
`timescale 1ns/10ps
`include "lpts_map.svh"

// ------------------------------------------------------------
// ------------------------------------------------------------
module lcd_panel_timing_status
    import lpts_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output lpts_vd_t         video_data_bus_out,
    output lpts_vd_t         video_data_oe_out,
    output logic             palette_busy_out,
    output logic             panel_timing_ctrl_enable_out,
    output logic             panel_resolution_select_out
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [10:0]  width;
    logic [10:0]  next_width;
    logic         layout_i;
    logic         next_layout_i;
    logic         tft_en;
    logic         next_tft_en;
    logic         panel_timing_ctrl_enable;
    logic         next_panel_timing_ctrl_enable;
    logic         panel_resolution_select;
    logic         next_panel_resolution_select;
    logic [31:0]  timing;
    logic [31:0]  next_timing;
    logic [15:0]  pixel;
    logic [15:0]  next_pixel;
    logic [31:0]  next_prdata;
    logic         next_pready;
    logic         next_pslverr;
    lpts_phase_e  line_phase;
    lpts_phase_e  frame_phase;
    logic         line_wrap;
    logic         run;
    lpts_timing_s tm;
    lpts_vd_t     next_vd;
    lpts_vd_t     next_oe;

    function automatic logic [10:0] widen4(input logic [3:0] v);
        widen4 = {7'h00, v};
    endfunction

    assign run = tft_en;
    always_comb begin
        tm.width  = width;
        tm.hsync  = timing[3:0];
        tm.hback  = timing[7:4];
        tm.hfront = timing[11:8];
        tm.vsync  = timing[15:12];
        tm.vback  = timing[19:16];
        tm.vfront = timing[23:20];
        tm.lines  = {timing[31:24], 2'b00};
    end

    // ------------------------------------------------------------
    // Scan phase counters
    // ------------------------------------------------------------
    lpts_phase_cnt #(.W(11)) u_line (
        .ref_clk_in   (ref_clk_in),
        .reset_n_in   (reset_n_in),
        .run_in       (run),
        .step_in      (1'b1),
        .sync_len_in  (widen4(tm.hsync)),
        .back_len_in  (widen4(tm.hback)),
        .actv_len_in  (tm.width),
        .front_len_in (widen4(tm.hfront)),
        .phase_out    (line_phase),
        .wrap_out     (line_wrap)
    );

    lpts_phase_cnt #(.W(11)) u_frame (
        .ref_clk_in   (ref_clk_in),
        .reset_n_in   (reset_n_in),
        .run_in       (run),
        .step_in      (line_wrap),
        .sync_len_in  (widen4(tm.vsync)),
        .back_len_in  (widen4(tm.vback)),
        .actv_len_in  ({1'b0, tm.lines}),
        .front_len_in (widen4(tm.vfront)),
        .phase_out    (frame_phase),
        .wrap_out     ()
    );

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    always_comb begin
        next_width    = width;
        next_layout_i = layout_i;
        next_tft_en   = tft_en;
        next_panel_timing_ctrl_enable   = panel_timing_ctrl_enable;
        next_panel_resolution_select  = panel_resolution_select;
        next_timing   = timing;
        next_pixel    = pixel;
        next_prdata   = prdata_out;
        next_pready   = 1'b0;
        next_pslverr  = 1'b0;
        if (psel_in && !penable_in) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            case (paddr_in)
                `LPTS_GEOM_OFFSET: begin
                    next_prdata[`LPTS_WIDTH_MSB:`LPTS_WIDTH_LSB] = width;
                end
                `LPTS_FORMAT_OFFSET: begin
                    // Upper bits stay zero
                    next_prdata[`LPTS_FRAME_MSB:`LPTS_FRAME_LSB] = frame_phase;
                    next_prdata[`LPTS_LINE_MSB:`LPTS_LINE_LSB]   = line_phase;
                    next_prdata[`LPTS_LAYOUT_BIT]                = layout_i;
                    next_prdata[`LPTS_TFT_BIT]                   = tft_en;
                end
                `LPTS_SELECT_OFFSET: begin
                    next_prdata[`LPTS_ENABLE_BIT] = panel_timing_ctrl_enable;
                    next_prdata[`LPTS_RES_BIT]    = panel_resolution_select;
                end
                `LPTS_TIMING_OFFSET: begin
                    next_prdata = timing;
                end
                `LPTS_PIXEL_OFFSET: begin
                    next_prdata[15:0] = pixel;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        // Writes land at the access edge, where the master sees pready high
        if (psel_in && penable_in && pready_out && pwrite_in) begin
            case (paddr_in)
                `LPTS_GEOM_OFFSET: begin
                    next_width = pwdata_in[`LPTS_WIDTH_MSB:`LPTS_WIDTH_LSB];
                end
                `LPTS_FORMAT_OFFSET: begin
                    next_layout_i = pwdata_in[`LPTS_LAYOUT_BIT];
                    next_tft_en   = pwdata_in[`LPTS_TFT_BIT];
                end
                `LPTS_SELECT_OFFSET: begin
                    next_panel_timing_ctrl_enable  = pwdata_in[`LPTS_ENABLE_BIT];
                    next_panel_resolution_select = pwdata_in[`LPTS_RES_BIT];
                end
                `LPTS_TIMING_OFFSET: begin
                    next_timing = pwdata_in;
                end
                `LPTS_PIXEL_OFFSET: begin
                    next_pixel = pwdata_in[15:0];
                end
                default: begin
                    next_pixel = pixel;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            width       <= `LPTS_WIDTH_RESET;
            layout_i    <= 1'b0;
            tft_en      <= 1'b0;
            panel_timing_ctrl_enable      <= 1'b0;
            panel_resolution_select     <= 1'b0;
            timing      <= `LPTS_TIMING_RESET;
            pixel       <= 16'h0000;
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            width       <= next_width;
            layout_i    <= next_layout_i;
            tft_en      <= next_tft_en;
            panel_timing_ctrl_enable      <= next_panel_timing_ctrl_enable;
            panel_resolution_select     <= next_panel_resolution_select;
            timing      <= next_timing;
            pixel       <= next_pixel;
            prdata_out  <= next_prdata;
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Video data placement
    // ------------------------------------------------------------
    always_comb begin
        next_vd = 24'h00_0000;
        next_oe = 24'hFF_FFFF;
        if (line_phase == LPTS_PH_ACTV && frame_phase == LPTS_PH_ACTV) begin
            if (!layout_i) begin
                next_vd[23:19] = pixel[15:11];
                next_vd[15:10] = pixel[10:5];
                next_vd[7:3]   = pixel[4:0];
                next_oe        = 24'h07_03_07;
            end else begin
                next_vd[23:18] = {pixel[15:11], pixel[0]};
                next_vd[15:10] = {pixel[10:6], pixel[0]};
                next_vd[7:2]   = {pixel[5:1], pixel[0]};
                next_oe        = 24'h03_03_03;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            video_data_bus_out           <= 24'h00_0000;
            video_data_oe_out            <= 24'hFF_FFFF;
            palette_busy_out             <= 1'b0;
            panel_timing_ctrl_enable_out <= 1'b0;
            panel_resolution_select_out  <= 1'b0;
        end else begin
            video_data_bus_out           <= next_vd;
            video_data_oe_out            <= next_oe;
            palette_busy_out             <= (line_phase == LPTS_PH_ACTV) || (frame_phase == LPTS_PH_ACTV);
            panel_timing_ctrl_enable_out <= panel_timing_ctrl_enable;
            panel_resolution_select_out  <= panel_resolution_select;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    line_order_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (line_phase != $past(line_phase)) && run |->
        (line_phase == LPTS_PH_SYNC || line_phase == lpts_phase_e'($past(line_phase) + 2'd1)))
        else $error("line phase out of order");
    frame_order_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (frame_phase != $past(frame_phase)) && run |->
        (frame_phase == LPTS_PH_SYNC || frame_phase == lpts_phase_e'($past(frame_phase) + 2'd1)))
        else $error("frame phase out of order");
    idle_sync_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        !run |=> line_phase == LPTS_PH_SYNC && frame_phase == LPTS_PH_SYNC)
        else $error("phase not sync while stopped");
    status_read_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        psel_in && !penable_in && !pwrite_in && paddr_in == `LPTS_FORMAT_OFFSET |=>
        prdata_out[16:15] == $past(frame_phase) && prdata_out[14:13] == $past(line_phase)
        && prdata_out[31:17] == 15'h0000)
        else $error("format status read wrong");
    width_write_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == `LPTS_GEOM_OFFSET |=>
        width == $past(pwdata_in[18:8]))
        else $error("width not stored");
    lpc_enable_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == `LPTS_SELECT_OFFSET |=>
        ##1 panel_timing_ctrl_enable_out == $past(pwdata_in[0], 2))
        else $error("timing ctrl enable wrong");
    pixel_565_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        line_phase == LPTS_PH_ACTV && frame_phase == LPTS_PH_ACTV && !layout_i |=>
        video_data_bus_out[23:19] == $past(pixel[15:11]) && video_data_oe_out[23:19] == 5'h00)
        else $error("red placement wrong");
    free_lines_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        1'b1 |=> (video_data_bus_out & video_data_oe_out) == 24'h00_0000)
        else $error("unused line driven");
    busy_flag_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        line_phase == LPTS_PH_ACTV |=> palette_busy_out)
        else $error("palette busy missing");

    frame_wrap_c: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        frame_phase == LPTS_PH_FRONT ##1 frame_phase == LPTS_PH_SYNC);
    active_555_c: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        layout_i && line_phase == LPTS_PH_ACTV && frame_phase == LPTS_PH_ACTV);
    bad_addr_c: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) pslverr_out);

endmodule // lcd_panel_timing_status

// file: dv/lpts_panel_model.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Panel driver model: resolves video lines, captures pixels
// ------------------------------------------------------------
module lpts_panel_model
    import lpts_pkg::*;
(
    input  wire logic     ref_clk_in,
    input  wire logic     clear_in,
    input  wire lpts_vd_t video_data_bus_in,
    input  wire lpts_vd_t video_data_oe_in,
    output lpts_vd_t      pixel_out,
    output lpts_vd_t      driven_out
);
    lpts_vd_t wire_level;
    lpts_vd_t last_level = '0;

    // Free lines have no pull: they show the inverse of the last level
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            wire_level[i] = video_data_oe_in[i] ? ~last_level[i] : video_data_bus_in[i];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        last_level <= wire_level;
        if (clear_in) begin
            driven_out <= '0;
        end else begin
            driven_out <= driven_out | ~video_data_oe_in;
            if (video_data_oe_in[23] === 1'b0 && video_data_bus_in != '0) begin
                pixel_out <= wire_level;
            end
        end
    end
endmodule // lpts_panel_model

// file: dv/test_lcd_panel_timing_status.sv
`timescale 1ns/10ps
`include "lpts_map.svh"

// ------------------------------------------------------------
// Register, phase and pixel layout bench
// ------------------------------------------------------------
module test_lcd_panel_timing_status import lpts_pkg::*;;
    localparam logic [15:0] PIX = 16'hA5C3;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        clear   = 1'b1;
    logic [31:0] rd;
    logic        er;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic        panel_timing_ctrl_enable;
    logic        panel_resolution_select;
    lpts_vd_t    vd;
    lpts_vd_t    vd_oe;
    lpts_vd_t    pix;
    lpts_vd_t    drv;
    int          errors    = 0;
    int          tests_run = 0;
    int          cycles    = 0;

    always #50 ref_clk = ~ref_clk;

    lcd_panel_timing_status DUT (
        .ref_clk_in                   (ref_clk),
        .reset_n_in                   (reset_n),
        .psel_in                      (psel),
        .penable_in                   (penable),
        .pwrite_in                    (pwrite),
        .paddr_in                     (paddr),
        .pwdata_in                    (pwdata),
        .prdata_out                   (prdata),
        .pready_out                   (pready),
        .pslverr_out                  (pslverr),
        .video_data_bus_out           (vd),
        .video_data_oe_out            (vd_oe),
        .palette_busy_out             (busy),
        .panel_timing_ctrl_enable_out (panel_timing_ctrl_enable),
        .panel_resolution_select_out  (panel_resolution_select)
    );

    lpts_panel_model panel (
        .ref_clk_in        (ref_clk),
        .clear_in          (clear),
        .video_data_bus_in (vd),
        .video_data_oe_in  (vd_oe),
        .pixel_out         (pix),
        .driven_out        (drv)
    );

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // APB transfer: setup, access, wait for pready
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Track both phase fields; each change must be a single step
    task automatic poll_phases(input int reads);
        logic [1:0] lp;
        logic [1:0] fp;
        int         both;
        both = 0;
        apb(1'b0, `LPTS_FORMAT_OFFSET, 32'h0000_0000);
        lp = rd[14:13];
        fp = rd[16:15];
        for (int i = 0; i < reads; i++) begin
            apb(1'b0, `LPTS_FORMAT_OFFSET, 32'h0000_0000);
            if (rd[14:13] != lp) begin
                check({30'h0, rd[14:13]}, {30'h0, lp + 2'h1});
            end
            if (rd[16:15] != fp) begin
                check({30'h0, rd[16:15]}, {30'h0, fp + 2'h1});
            end
            if (rd[14:13] == LPTS_PH_ACTV && rd[16:15] == LPTS_PH_ACTV) begin
                both++;
            end
            lp = rd[14:13];
            fp = rd[16:15];
        end
        check({31'h0, both > 0}, 32'h0000_0001);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            $display("BAD at %0t: run took too long", $time);
            stop_test();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        check({8'h00, vd_oe}, 32'h00FF_FFFF);
        check({31'h0, busy}, 32'h0000_0000);
        apb(1'b0, `LPTS_GEOM_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, `LPTS_FORMAT_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, `LPTS_SELECT_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        $display("test reset values done");

        apb(1'b1, `LPTS_GEOM_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, `LPTS_GEOM_OFFSET, 32'h0000_0000);
        check({21'h0, rd[18:8]}, 32'h0000_07FF);
        apb(1'b1, `LPTS_FORMAT_OFFSET, 32'h0001_FFFE);
        apb(1'b0, `LPTS_FORMAT_OFFSET, 32'h0000_0000);
        check(rd & 32'hFFFF_E000, 32'h0000_0000);
        apb(1'b1, `LPTS_SELECT_OFFSET, 32'h0000_0003);
        // Register, then output flop: settled one edge later
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({30'h0, panel_timing_ctrl_enable, panel_resolution_select}, 32'h0000_0003);
        apb(1'b0, `LPTS_SELECT_OFFSET, 32'h0000_0000);
        check({31'h0, rd[0]}, 32'h0000_0001);
        apb(1'b1, `LPTS_SELECT_OFFSET, 32'h0000_0000);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({31'h0, panel_timing_ctrl_enable}, 32'h0000_0000);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        check({31'h0, er}, 32'h0000_0001);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check({rd[31:1], er}, 32'h0000_0001);
        $display("test register access done");

        // Width 40 counts 0 to 40: 41 dots of 16 bits, 82 bytes a line
        apb(1'b1, `LPTS_PIXEL_OFFSET, {16'h0000, PIX});
        apb(1'b1, `LPTS_GEOM_OFFSET, 32'h0000_2800);
        apb(1'b1, `LPTS_TIMING_OFFSET, 32'h0133_3333);
        clear <= 1'b0;
        apb(1'b1, `LPTS_FORMAT_OFFSET, 32'h0000_0001);
        poll_phases(400);
        check({8'h00, pix & 24'hF8_FCF8}, {8'h00, PIX[15:11], 3'h0, PIX[10:5], 2'h0, PIX[4:0], 3'h0});
        check({8'h00, drv}, 32'h00F8_FCF8);
        $display("test 5:6:5 layout done");

        clear <= 1'b1;
        apb(1'b1, `LPTS_FORMAT_OFFSET, 32'h0000_0801);
        clear <= 1'b0;
        poll_phases(400);
        check({8'h00, pix & 24'hFC_FCFC}, {8'h00, PIX[15:11], PIX[0], 2'h0, PIX[10:6], PIX[0], 2'h0, PIX[5:1], PIX[0], 2'h0});
        check({8'h00, drv}, 32'h00FC_FCFC);
        $display("test 5:5:5:I layout done");
        stop_test();
    end
endmodule // test_lcd_panel_timing_status
